// ===== ialu_pkg.sv
package ialu_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] IALU_A_OPA   = 12'h000;
  localparam logic [11:0] IALU_A_OPB   = 12'h004;
  localparam logic [11:0] IALU_A_CTRL  = 12'h008;
  localparam logic [11:0] IALU_A_FLAGS = 12'h00C;
  localparam logic [11:0] IALU_A_RESLO = 12'h010;
  localparam logic [11:0] IALU_A_RESHI = 12'h014;
  localparam logic [11:0] IALU_A_STAT  = 12'h018;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int IALU_CTRL_OP_LSB = 0;
  localparam int IALU_CTRL_WD_LSB = 8;
  localparam int IALU_STAT_BUSY   = 0;
  localparam int IALU_STAT_DONE   = 1;
  localparam int IALU_STAT_DZ     = 2;
  localparam int IALU_CARRY_FLAG  = 0;
  localparam int IALU_PARITY_FLAG = 2;
  localparam int IALU_AUX_FLAG    = 4;
  localparam int IALU_ZERO_FLAG   = 6;
  localparam int IALU_SIGN_FLAG   = 7;
  localparam int IALU_OVF_FLAG    = 11;

  localparam logic [11:0] IALU_FL_RST  = 12'h000;
  localparam logic [11:0] IALU_FL_MASK = 12'h8D5;

  // operand widths, and extension moves
  localparam logic [1:0] IALU_W8     = 2'h0;
  localparam logic [1:0] IALU_W16    = 2'h1;
  localparam logic [1:0] IALU_W32    = 2'h2;
  localparam logic [1:0] IALU_X8_16  = 2'h0;
  localparam logic [1:0] IALU_X8_32  = 2'h1;
  localparam logic [1:0] IALU_X16_32 = 2'h2;

  // ----------------------------------------------------------------
  // counts and decimal constants
  // ----------------------------------------------------------------
  localparam logic [5:0] IALU_DIV_STEPS = 6'h20;
  localparam logic [3:0] IALU_DIGIT_MAX = 4'h9;
  localparam logic [7:0] IALU_TEN       = 8'h0A;
  localparam logic [7:0] IALU_SIX       = 8'h06;
  localparam logic [7:0] IALU_SIXTY     = 8'h60;
  localparam logic [7:0] IALU_BCD_MAX   = 8'h99;

  typedef enum logic [4:0] {
    IALU_OP_ADD          = 5'h00,
    IALU_OP_CARRY_ADD    = 5'h01,
    IALU_OP_DIFF         = 5'h02,
    IALU_OP_BORROW_DIFF  = 5'h03,
    IALU_OP_COUNT_UP     = 5'h04,
    IALU_OP_COUNT_DOWN   = 5'h05,
    IALU_OP_COMPARE      = 5'h06,
    IALU_OP_SIGN_FLIP    = 5'h07,
    IALU_OP_UPROD        = 5'h08,
    IALU_OP_SPROD        = 5'h09,
    IALU_OP_SPROD_TRUNC  = 5'h0A,
    IALU_OP_UQUOT        = 5'h0B,
    IALU_OP_SQUOT        = 5'h0C,
    IALU_OP_AND          = 5'h0D,
    IALU_OP_OR           = 5'h0E,
    IALU_OP_XOR          = 5'h0F,
    IALU_OP_NOT          = 5'h10,
    IALU_OP_WORD_FILL    = 5'h11,
    IALU_OP_DWORD_FILL   = 5'h12,
    IALU_OP_SEXT_MOVE    = 5'h13,
    IALU_OP_ZEXT_MOVE    = 5'h14,
    IALU_OP_BCD_ADD_ADJ  = 5'h15,
    IALU_OP_BCD_DIFF_ADJ = 5'h16,
    IALU_OP_UNP_ADD_ADJ  = 5'h17,
    IALU_OP_UNP_SUB_ADJ  = 5'h18,
    IALU_OP_UNP_MUL_ADJ  = 5'h19,
    IALU_OP_UNP_DIV_ADJ  = 5'h1A
  } ialu_op_e;

  typedef enum logic [2:0] {
    IALU_ST_IDLE = 3'b001,
    IALU_ST_EXEC = 3'b010,
    IALU_ST_DIV  = 3'b100
  } ialu_st_e;

  typedef struct packed {
    ialu_st_e    st;
    logic [31:0] opa;
    logic [31:0] opb;
    ialu_op_e    op;
    logic [1:0]  wd;
    logic [11:0] fl;
    logic [31:0] lo;
    logic [31:0] hi;
    logic        done;
    logic        dz;
    logic [32:0] rem;
    logic [31:0] quo;
    logic [5:0]  cnt;
    logic [31:0] prdata;
    logic        pslverr;
  } ialu_state_s;

  localparam ialu_state_s IALU_STATE_RST = '{st: IALU_ST_IDLE,
    op: IALU_OP_ADD, fl: IALU_FL_RST, default: '0};

endpackage : ialu_pkg

// ===== ialu_top.sv
// Notes on behaviour
// - word fill copies bit 15 into ext word
// - dword fill copies bit 31 into ext dword
// - sign extend move widens with sign copies
// - zero extend move widens with zero bits
// - arithmetic on 8, 16, 32 bit operands
// - add gives sum, diff gives a minus b
// - carry add adds one more on carry
// - borrow diff takes one more on carry
// - count up adds one, down subtracts one
// - compare only updates six status flags
// - sign flip gives zero minus operand
// - unsigned product is double width
// - signed product double width or truncated
// - unsigned divide gives quotient and remainder
// - signed divide same but signed operands
// - packed add adjust, carry on decimal carry
// - packed diff adjust, carry on decimal borrow
// - unpacked add adjust, carry bumps high byte
// - unpacked sub adjust, borrow drops high byte
// - unpacked mul adjust splits into digits
// - unpacked div adjust joins digits to binary
// - and, or, xor, not on operands
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps

module ialu_top
  import ialu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // width helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wmask(input logic [1:0] w);
    if (w == IALU_W8) wmask = 32'h0000_00FF;
    else if (w == IALU_W16) wmask = 32'h0000_FFFF;
    else wmask = 32'hFFFF_FFFF;
  endfunction : wmask

  function automatic logic msb_at(input logic [31:0] v,
                                  input logic [1:0] w);
    if (w == IALU_W8) msb_at = v[7];
    else if (w == IALU_W16) msb_at = v[15];
    else msb_at = v[31];
  endfunction : msb_at

  function automatic logic cy_at(input logic [32:0] v,
                                 input logic [1:0] w);
    if (w == IALU_W8) cy_at = v[8];
    else if (w == IALU_W16) cy_at = v[16];
    else cy_at = v[32];
  endfunction : cy_at

  function automatic logic [31:0] sext(input logic [31:0] v,
                                       input logic [1:0] w);
    if (w == IALU_W8) sext = {{24{v[7]}}, v[7:0]};
    else if (w == IALU_W16) sext = {{16{v[15]}}, v[15:0]};
    else sext = v;
  endfunction : sext

  function automatic logic [31:0] upper(input logic [63:0] p,
                                        input logic [1:0] w);
    if (w == IALU_W8) upper = {24'h0, p[15:8]};
    else if (w == IALU_W16) upper = {16'h0, p[31:16]};
    else upper = p[63:32];
  endfunction : upper

  function automatic logic addr_ok(input logic [11:0] ad);
    addr_ok = (ad == IALU_A_OPA) || (ad == IALU_A_OPB) ||
              (ad == IALU_A_CTRL) || (ad == IALU_A_FLAGS) ||
              (ad == IALU_A_RESLO) || (ad == IALU_A_RESHI) ||
              (ad == IALU_A_STAT);
  endfunction : addr_ok

  ialu_state_s        state_ff;
  ialu_state_s        nxt_state;
  logic        [31:0] m;
  logic        [31:0] a;
  logic        [31:0] b;
  logic        [31:0] aa;
  logic        [31:0] bb;
  logic        [31:0] rs;
  logic        [31:0] r;
  logic        [31:0] rh;
  logic        [31:0] ea;
  logic        [31:0] eb;
  logic        [31:0] mag_a;
  logic        [31:0] mag_b;
  logic        [31:0] nq;
  logic        [31:0] rd;
  logic        [32:0] s33;
  logic        [32:0] rsh;
  logic        [32:0] nr;
  logic        [63:0] pu;
  logic signed [63:0] ps;
  logic        [7:0]  al;
  logic        [7:0]  ah;
  logic        [7:0]  al2;
  logic        [7:0]  ah2;
  logic        [1:0]  fw;
  logic               ci;
  logic               sub;
  logic               c;
  logic               o;
  logic               x;
  logic               uc;
  logic               uo;
  logic               ux;
  logic               us;
  logic               wl;
  logic               wh;
  logic               sgn;
  logic               cf;
  logic               af;
  logic               busy;
  logic               wr;

  always_comb begin
    nxt_state = state_ff;
    busy = (state_ff.st != IALU_ST_IDLE);
    wr = psel && penable && pwrite && !state_ff.pslverr;
    m = wmask(state_ff.wd);
    a = state_ff.opa & m;
    b = state_ff.opb & m;
    cf = state_ff.fl[IALU_CARRY_FLAG];
    af = state_ff.fl[IALU_AUX_FLAG];
    al = state_ff.opa[7:0];
    ah = state_ff.opa[15:8];
    al2 = al;
    ah2 = ah;
    sgn = state_ff.op inside {IALU_OP_SQUOT, IALU_OP_SPROD,
                              IALU_OP_SPROD_TRUNC};
    ea = sgn ? sext(state_ff.opa, state_ff.wd) : a;
    eb = sgn ? sext(state_ff.opb, state_ff.wd) : b;
    mag_a = (sgn && ea[31]) ? (32'h0 - ea) : ea;
    mag_b = (sgn && eb[31]) ? (32'h0 - eb) : eb;
    rsh = {state_ff.rem[31:0], state_ff.quo[31]};
    nr = (rsh >= {1'b0, mag_b}) ? (rsh - {1'b0, mag_b}) : rsh;
    nq = {state_ff.quo[30:0], (rsh >= {1'b0, mag_b})};
    pu = {32'h0, a} * {32'h0, b};
    ps = $signed({{32{ea[31]}}, sext(state_ff.opa, state_ff.wd)}) *
         $signed({{32{eb[31]}}, sext(state_ff.opb, state_ff.wd)});
    // ----------------------------------------------------------------
    // shared adder
    // ----------------------------------------------------------------
    aa = a;
    bb = b;
    ci = 1'b0;
    sub = 1'b0;
    case (state_ff.op)
      IALU_OP_CARRY_ADD: ci = cf;
      IALU_OP_DIFF: sub = 1'b1;
      IALU_OP_BORROW_DIFF: begin
        sub = 1'b1;
        ci = cf;
      end
      IALU_OP_COMPARE: sub = 1'b1;
      IALU_OP_COUNT_UP: bb = 32'h1;
      IALU_OP_COUNT_DOWN: begin
        bb = 32'h1;
        sub = 1'b1;
      end
      IALU_OP_SIGN_FLIP: begin
        aa = 32'h0;
        bb = a;
        sub = 1'b1;
      end
      default: ;
    endcase
    s33 = sub ? ({1'b0, aa} - {1'b0, bb} - {32'h0, ci})
              : ({1'b0, aa} + {1'b0, bb} + {32'h0, ci});
    rs = s33[31:0] & m;
    // ----------------------------------------------------------------
    // per operation result
    // ----------------------------------------------------------------
    r = rs;
    rh = state_ff.hi;
    c = cy_at(s33, state_ff.wd);
    x = aa[4] ^ bb[4] ^ rs[4];
    o = sub ? ((msb_at(aa, state_ff.wd) != msb_at(bb, state_ff.wd)) &&
               (msb_at(rs, state_ff.wd) != msb_at(aa, state_ff.wd)))
            : ((msb_at(aa, state_ff.wd) == msb_at(bb, state_ff.wd)) &&
               (msb_at(rs, state_ff.wd) != msb_at(aa, state_ff.wd)));
    fw = state_ff.wd;
    {uc, uo, ux, us, wl, wh} = 6'h00;
    case (state_ff.op)
      IALU_OP_ADD, IALU_OP_CARRY_ADD, IALU_OP_DIFF, IALU_OP_BORROW_DIFF,
      IALU_OP_SIGN_FLIP: {uc, uo, ux, us, wl} = 5'h1F;
      IALU_OP_COUNT_UP, IALU_OP_COUNT_DOWN: {uo, ux, us, wl} = 4'hF;
      IALU_OP_COMPARE: {uc, uo, ux, us} = 4'hF;
      IALU_OP_AND, IALU_OP_OR, IALU_OP_XOR: begin
        if (state_ff.op == IALU_OP_AND) r = a & b;
        else if (state_ff.op == IALU_OP_OR) r = a | b;
        else r = a ^ b;
        {c, o, x} = 3'h0;
        {uc, uo, ux, us, wl} = 5'h1F;
      end
      IALU_OP_NOT: begin
        r = ~a & m;
        wl = 1'b1;
      end
      IALU_OP_WORD_FILL: begin
        r = state_ff.opa;
        rh = {16'h0, {16{state_ff.opa[15]}}};
        {wl, wh} = 2'h3;
      end
      IALU_OP_DWORD_FILL: begin
        r = state_ff.opa;
        rh = {32{state_ff.opa[31]}};
        {wl, wh} = 2'h3;
      end
      IALU_OP_SEXT_MOVE, IALU_OP_ZEXT_MOVE: begin
        sgn = (state_ff.op == IALU_OP_SEXT_MOVE);
        if (state_ff.wd == IALU_X8_16)
          r = {16'h0, {8{sgn & al[7]}}, al};
        else if (state_ff.wd == IALU_X8_32)
          r = {{24{sgn & al[7]}}, al};
        else
          r = {{16{sgn & state_ff.opa[15]}}, state_ff.opa[15:0]};
        wl = 1'b1;
      end
      IALU_OP_UPROD: begin
        r = pu[31:0] & m;
        rh = upper(pu, state_ff.wd);
        c = (rh != 32'h0);
        o = c;
        {uc, uo, wl, wh} = 4'hF;
      end
      IALU_OP_SPROD, IALU_OP_SPROD_TRUNC: begin
        r = ps[31:0] & m;
        rh = upper(ps, state_ff.wd);
        c = ({{32{ps[63]}}, ps[31:0]} !=
             {{32{msb_at(r, state_ff.wd)}}, sext(r, state_ff.wd)});
        o = c;
        wh = (state_ff.op == IALU_OP_SPROD);
        {uc, uo, wl} = 3'h7;
      end
      IALU_OP_BCD_ADD_ADJ, IALU_OP_BCD_DIFF_ADJ: begin
        sub = (state_ff.op == IALU_OP_BCD_DIFF_ADJ);
        x = (al[3:0] > IALU_DIGIT_MAX) || af;
        c = (al > IALU_BCD_MAX) || cf;
        if (x) al2 = sub ? (al2 - IALU_SIX) : (al2 + IALU_SIX);
        if (c) al2 = sub ? (al2 - IALU_SIXTY) : (al2 + IALU_SIXTY);
      end
      IALU_OP_UNP_ADD_ADJ, IALU_OP_UNP_SUB_ADJ: begin
        sub = (state_ff.op == IALU_OP_UNP_SUB_ADJ);
        c = (al[3:0] > IALU_DIGIT_MAX) || af;
        x = c;
        if (c) begin
          al2 = sub ? (al - IALU_SIX) : (al + IALU_SIX);
          ah2 = sub ? (ah - 8'h01) : (ah + 8'h01);
        end
        al2 = al2 & 8'h0F;
      end
      IALU_OP_UNP_MUL_ADJ: begin
        ah2 = al / IALU_TEN;
        al2 = al % IALU_TEN;
      end
      IALU_OP_UNP_DIV_ADJ: begin
        al2 = (ah * IALU_TEN) + al;
        ah2 = 8'h00;
      end
      default: ;
    endcase
    if ((state_ff.op >= IALU_OP_BCD_ADD_ADJ) &&
        (state_ff.op <= IALU_OP_UNP_DIV_ADJ)) begin
      r = {state_ff.opa[31:16], ah2, al2};
      fw = IALU_W8;
      us = 1'b1;
      wl = 1'b1;
      {uc, ux} = (state_ff.op >= IALU_OP_UNP_MUL_ADJ) ? 2'h0 : 2'h3;
    end
    // ----------------------------------------------------------------
    // register read and write
    // ----------------------------------------------------------------
    rd = 32'h0;
    if (paddr == IALU_A_OPA) rd = state_ff.opa;
    else if (paddr == IALU_A_OPB) rd = state_ff.opb;
    else if (paddr == IALU_A_CTRL) begin
      rd[IALU_CTRL_OP_LSB +: 5] = state_ff.op;
      rd[IALU_CTRL_WD_LSB +: 2] = state_ff.wd;
    end
    else if (paddr == IALU_A_FLAGS) rd = {20'h0, state_ff.fl};
    else if (paddr == IALU_A_RESLO) rd = state_ff.lo;
    else if (paddr == IALU_A_RESHI) rd = state_ff.hi;
    else if (paddr == IALU_A_STAT) begin
      rd[IALU_STAT_BUSY] = busy;
      rd[IALU_STAT_DONE] = state_ff.done;
      rd[IALU_STAT_DZ] = state_ff.dz;
    end
    if (psel && !penable) begin
      nxt_state.prdata = pwrite ? 32'h0 : rd;
      nxt_state.pslverr = !addr_ok(paddr) || (pwrite && busy);
    end
    if (wr) begin
      if (paddr == IALU_A_OPA) nxt_state.opa = pwdata;
      else if (paddr == IALU_A_OPB) nxt_state.opb = pwdata;
      else if (paddr == IALU_A_FLAGS)
        nxt_state.fl = pwdata[11:0] & IALU_FL_MASK;
      else if (paddr == IALU_A_CTRL) begin
        nxt_state.op = ialu_op_e'(pwdata[IALU_CTRL_OP_LSB +: 5]);
        nxt_state.wd = pwdata[IALU_CTRL_WD_LSB +: 2];
        nxt_state.st = IALU_ST_EXEC;
        nxt_state.done = 1'b0;
        nxt_state.dz = 1'b0;
      end
    end
    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    case (state_ff.st)
      IALU_ST_EXEC: begin
        nxt_state.st = IALU_ST_IDLE;
        nxt_state.done = 1'b1;
        if ((state_ff.op == IALU_OP_UQUOT) ||
            (state_ff.op == IALU_OP_SQUOT)) begin
          if (mag_b == 32'h0) nxt_state.dz = 1'b1;
          else begin
            nxt_state.done = 1'b0;
            nxt_state.st = IALU_ST_DIV;
            nxt_state.rem = 33'h0;
            nxt_state.quo = mag_a;
            nxt_state.cnt = IALU_DIV_STEPS;
          end
        end
        else begin
          if (wl) nxt_state.lo = r;
          if (wh) nxt_state.hi = rh;
          if (uc) nxt_state.fl[IALU_CARRY_FLAG] = c;
          if (uo) nxt_state.fl[IALU_OVF_FLAG] = o;
          if (ux) nxt_state.fl[IALU_AUX_FLAG] = x;
          if (us) begin
            nxt_state.fl[IALU_ZERO_FLAG] = ((r & wmask(fw)) == 32'h0);
            nxt_state.fl[IALU_SIGN_FLAG] = msb_at(r, fw);
            nxt_state.fl[IALU_PARITY_FLAG] = ~^r[7:0];
          end
        end
      end
      IALU_ST_DIV: begin
        nxt_state.rem = nr;
        nxt_state.quo = nq;
        nxt_state.cnt = state_ff.cnt - 6'h01;
        if (state_ff.cnt == 6'h01) begin
          nxt_state.lo = (((sgn && (ea[31] ^ eb[31])) ? (32'h0 - nq)
                           : nq) & m);
          nxt_state.hi = (((sgn && ea[31]) ? (32'h0 - nr[31:0])
                           : nr[31:0]) & m);
          nxt_state.done = 1'b1;
          nxt_state.st = IALU_ST_IDLE;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_ff <= IALU_STATE_RST;
    else state_ff <= nxt_state;
  end

  assign prdata = state_ff.prdata;
  assign pslverr = state_ff.pslverr;
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic ex;
  assign ex = (state_ff.st == IALU_ST_EXEC);

  sequence div_go;
    ex && (state_ff.op == IALU_OP_UQUOT) && (state_ff.wd == IALU_W32) &&
      (state_ff.opb != 32'h0);
  endsequence

  sequence div_end;
    state_ff.done && ({32'h0, state_ff.lo} * {32'h0, state_ff.opb} +
      {32'h0, state_ff.hi} == {32'h0, state_ff.opa});
  endsequence

  word_fill_a: assert property (ex && state_ff.op == IALU_OP_WORD_FILL
    |=> state_ff.hi == {16'h0, {16{state_ff.opa[15]}}})
    else $error("word fill wrong");
  dword_fill_a: assert property (ex && state_ff.op == IALU_OP_DWORD_FILL
    |=> state_ff.hi == {32{state_ff.opa[31]}})
    else $error("dword fill wrong");
  byte_sext_a: assert property (ex && state_ff.op == IALU_OP_SEXT_MOVE &&
    state_ff.wd == IALU_X8_32
    |=> state_ff.lo == {{24{state_ff.opa[7]}}, state_ff.opa[7:0]})
    else $error("sign extension wrong");
  add_sum_a: assert property (ex && state_ff.op == IALU_OP_ADD &&
    state_ff.wd == IALU_W16 |=> state_ff.lo ==
    {16'h0, state_ff.opa[15:0] + state_ff.opb[15:0]})
    else $error("sum wrong");
  carry_add_a: assert property (ex && state_ff.op == IALU_OP_CARRY_ADD &&
    state_ff.wd == IALU_W32 |=> state_ff.lo == state_ff.opa +
    state_ff.opb + {31'h0, $past(state_ff.fl[IALU_CARRY_FLAG])})
    else $error("carry add wrong");
  compare_keep_a: assert property (ex && state_ff.op == IALU_OP_COMPARE
    |=> $stable(state_ff.lo) && $stable(state_ff.opa) &&
    $stable(state_ff.opb))
    else $error("compare wrote a result");
  flip_neg_a: assert property (ex && state_ff.op == IALU_OP_SIGN_FLIP &&
    state_ff.wd == IALU_W32 |=> state_ff.lo == 32'h0 - state_ff.opa)
    else $error("negation wrong");
  uprod_a: assert property (ex && state_ff.op == IALU_OP_UPROD &&
    state_ff.wd == IALU_W32 |=> {state_ff.hi, state_ff.lo} ==
    {32'h0, state_ff.opa} * {32'h0, state_ff.opb})
    else $error("product wrong");
  udiv_a: assert property (div_go |-> ##33 div_end)
    else $error("divide result wrong");
  unp_add_a: assert property (ex && state_ff.op == IALU_OP_UNP_ADD_ADJ &&
    state_ff.opa[3:0] > IALU_DIGIT_MAX |=> state_ff.lo[15:8] ==
    $past(state_ff.opa[15:8]) + 8'h01 && state_ff.lo[7:4] == 4'h0 &&
    state_ff.fl[IALU_CARRY_FLAG])
    else $error("unpacked add adjust wrong");
  xor_a: assert property (ex && state_ff.op == IALU_OP_XOR &&
    state_ff.wd == IALU_W8 |=> state_ff.lo ==
    {24'h0, state_ff.opa[7:0] ^ state_ff.opb[7:0]})
    else $error("xor wrong");

endmodule : ialu_top

// ===== ialu_ctl_model.sv
`timescale 1ns/100ps

module ialu_ctl_model
  import ialu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer

  // ------------------------------------------------------------
  // one operation, status polled until not busy
  // ------------------------------------------------------------
  task automatic run(input logic [4:0] op, input logic [1:0] w,
                     input logic [31:0] a, b, fl,
                     output logic [31:0] st);
    logic [31:0] r;
    logic        e;
    int          n;
    xfer(1'b1, IALU_A_OPA, a, r, e);
    xfer(1'b1, IALU_A_OPB, b, r, e);
    xfer(1'b1, IALU_A_FLAGS, fl, r, e);
    xfer(1'b1, IALU_A_CTRL, {22'h0, w, 3'h0, op}, r, e);
    st = 32'h0000_0001;
    for (n = 0; n < 60 && st[IALU_STAT_BUSY] !== 1'b0; n++) begin
      xfer(1'b0, IALU_A_STAT, 32'h0, st, e);
    end
  endtask : run
endmodule : ialu_ctl_model

// ===== ialu_tb_top.sv
`timescale 1ns/100ps

module ialu_tb_top
  import ialu_pkg::*;
();
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr, a, b, x, st, rl, rh, rf, elo, ehi;
  logic [4:0]  op;
  logic [1:0]  w;
  logic        co, zf;
  int          n_mismatch, total_checks, i;

  ialu_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  ialu_ctl_model u_ctl (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    for (int k = 0; k < 32; k++) begin
      lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'h8020_0003 : 32'h0);
    end
    return lfsr;
  endfunction : rnd

  function automatic void model(input logic [4:0] o, input logic [1:0] wd,
    input logic [31:0] a0, b0, input logic ci, ai,
    inout logic [31:0] lo, hi, output logic c, z);
    logic [63:0] am, bm, p;
    logic signed [63:0] sa, sb;
    logic [32:0] s;
    logic [31:0] m;
    logic [7:0]  l, h;
    int          n;
    n  = (wd == IALU_W8) ? 8 : (wd == IALU_W16) ? 16 : 32;
    m  = (n == 32) ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1;
    am = {32'h0, a0 & m};
    bm = {32'h0, b0 & m};
    sa = $signed(am << (64 - n)) >>> (64 - n);
    sb = $signed(bm << (64 - n)) >>> (64 - n);
    l  = a0[7:0];
    h  = a0[15:8];
    c  = ci;
    s  = 33'h0;
    case (o)
      IALU_OP_ADD, IALU_OP_CARRY_ADD: s = 33'(am + bm + (o[0] & ci));
      IALU_OP_DIFF, IALU_OP_BORROW_DIFF, IALU_OP_COMPARE:
        s = 33'(am - bm - (o[0] & ci));
      IALU_OP_COUNT_UP:   s = 33'(am + 64'h1);
      IALU_OP_COUNT_DOWN: s = 33'(am - 64'h1);
      IALU_OP_SIGN_FLIP:  s = 33'(64'h0 - am);
      IALU_OP_UPROD: p = am * bm;
      IALU_OP_SPROD, IALU_OP_SPROD_TRUNC: p = sa * sb;
      IALU_OP_UQUOT: p = {32'(am % bm), 32'(am / bm)};
      IALU_OP_SQUOT: p = {32'(sa % sb), 32'(sa / sb)};
      IALU_OP_BCD_ADD_ADJ, IALU_OP_BCD_DIFF_ADJ: begin
        c = (l > IALU_BCD_MAX) | ci;
        s = {25'h0, ((l[3:0] > IALU_DIGIT_MAX) | ai) ? IALU_SIX : 8'h00};
        s[7:0] = s[7:0] | (c ? IALU_SIXTY : 8'h00);
        l = (o == IALU_OP_BCD_ADD_ADJ) ? l + s[7:0] : l - s[7:0];
      end
      IALU_OP_UNP_ADD_ADJ, IALU_OP_UNP_SUB_ADJ: begin
        c = (l[3:0] > IALU_DIGIT_MAX) | ai;
        l = (o == IALU_OP_UNP_ADD_ADJ) ? l + {4'h0, c, c, 1'b0} :
                                         l - {4'h0, c, c, 1'b0};
        h = (o == IALU_OP_UNP_ADD_ADJ) ? h + {7'h0, c} : h - {7'h0, c};
        l = l & 8'h0F;
      end
      IALU_OP_UNP_MUL_ADJ: {h, l} = {l / IALU_TEN, l % IALU_TEN};
      IALU_OP_UNP_DIV_ADJ: {h, l} = {8'h00, 8'(h * IALU_TEN + l)};
      default: ;
    endcase
    if (o <= 5'h06) c = (o == 5'h04 || o == 5'h05) ? ci : s[n];
    z = ((s[31:0] & m) == 32'h0);
    case (o)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07: lo = s[31:0] & m;
      5'h08, 5'h09: {hi, lo} = {32'(p >> n) & m, p[31:0] & m};
      5'h0B, 5'h0C: {hi, lo} = {p[63:32] & m, p[31:0] & m};
      5'h0A: lo = p[31:0] & m;
      5'h0D: lo = a0 & b0 & m;
      5'h0E: lo = (a0 | b0) & m;
      5'h0F: lo = (a0 ^ b0) & m;
      5'h10: lo = ~a0 & m;
      5'h11: {hi, lo} = {16'h0, {16{a0[15]}}, a0};
      5'h12: {hi, lo} = {{32{a0[31]}}, a0};
      5'h13: lo = (wd == IALU_X8_16) ? {16'h0, {8{l[7]}}, l} :
                  (wd == IALU_X8_32) ? {{24{l[7]}}, l} : {{16{h[7]}}, h, l};
      5'h14: lo = (wd == IALU_X16_32) ? {16'h0, h, l} : {24'h0, l};
      5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A: begin
        lo = {a0[31:16], h, l};
        z  = (l == 8'h00);
      end
      default: ;
    endcase
  endfunction : model

  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    results();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    lfsr = 32'h0000_4866;
    rst_n = 1'b0;
    {elo, ehi} = 64'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    u_ctl.xfer(1'b0, IALU_A_FLAGS, 32'h0, rf, e);
    chk(rf, {20'h0, IALU_FL_RST});
    u_ctl.xfer(1'b0, 12'h01C, 32'h0, rl, e);
    chk({rl[30:0], e}, 32'h1);
    for (i = 0; i < 108; i++) begin
      op = 5'(i % 27);
      w  = (i < 81) ? 2'(i / 27) : 2'(rnd() % 3);
      a  = (i < 27) ? 32'hFFFF_FFFF : rnd();
      b  = rnd();
      x  = rnd();
      if (op inside {[5'h11:5'h12], [5'h15:5'h1A]}) w = IALU_W32;
      if (op inside {[5'h0B:5'h0C]}) b[0] = 1'b1;
      u_ctl.run(op, w, a, b, {27'h0, x[1], 3'h0, x[0]}, st);
      u_ctl.xfer(1'b0, IALU_A_RESLO, 32'h0, rl, e);
      u_ctl.xfer(1'b0, IALU_A_RESHI, 32'h0, rh, e);
      u_ctl.xfer(1'b0, IALU_A_FLAGS, 32'h0, rf, e);
      model(op, w, a, b, x[0], x[1], elo, ehi, co, zf);
      chk({31'h0, st[IALU_STAT_DONE]}, 32'h1);
      if (op <= 5'h07)
        chk(rl, elo);
      else if (op <= 5'h10)
        chk(rl, elo);
      else if (op <= 5'h14) chk(rl, elo);
      else chk(rl, elo);
      chk(rh, ehi);
      if (op <= 5'h06 || op inside {[5'h15:5'h18]}) begin
        chk({rf[IALU_ZERO_FLAG], rf[IALU_CARRY_FLAG]},
          {zf, co});
      end
    end
    u_ctl.run(IALU_OP_UQUOT, IALU_W32, 32'h64, 32'h0, 32'h0, st);
    u_ctl.xfer(1'b0, IALU_A_RESLO, 32'h0, rl, e);
    chk({31'h0, st[IALU_STAT_DZ]}, 32'h1);
    chk(rl, elo);
    u_ctl.xfer(1'b1, IALU_A_OPB, 32'h7, rl, e);
    u_ctl.xfer(1'b1, IALU_A_CTRL, {22'h0, IALU_W32, 3'h0, IALU_OP_UQUOT},
      rl, e);
    u_ctl.xfer(1'b1, IALU_A_OPA, 32'h0, rl, e);
    chk({31'h0, e}, 32'h1);
    u_ctl.run(IALU_OP_ADD, IALU_W8, 32'h0, 32'h0, 32'h0, st);
    u_ctl.xfer(1'b0, IALU_A_RESLO, 32'h0, rl, e);
    chk(rl, 32'hE);
    repeat (40) @(posedge clk);
    u_ctl.xfer(1'b1, IALU_A_OPB, 32'h7, rl, e);
    u_ctl.run(IALU_OP_UQUOT, IALU_W32, 32'h64, 32'h7, 32'h0, st);
    u_ctl.xfer(1'b0, IALU_A_RESLO, 32'h0, rl, e);
    u_ctl.xfer(1'b0, IALU_A_RESHI, 32'h0, rh, e);
    chk({rh, rl}, {32'h2, 32'hE});
    results();
  end
endmodule : ialu_tb_top
